// File: pcq_consts.svh
/*
  Constants of the plane command queue: memory size, partition sizes,
  command word layout, operation codes, FIFO geometry and wait settling.
  Assumes inclusion by bare name from the design, processor model, checker and bench files.
*/
`ifndef PCQ_CONSTS_SVH
`define PCQ_CONSTS_SVH

// queue memory
`define PCQ_QUEUE_WORDS 13'd8000
`define PCQ_SIZE_ONE_PLANE 13'd8000
`define PCQ_SIZE_TWO_PLANES 13'd4000
`define PCQ_SIZE_FOUR_PLANES 13'd2000
`define PCQ_ADDR_W 13
`define PCQ_MAX_PLANES 4

// plane-count setting codes
`define PCQ_PLANES_ONE 2'h0
`define PCQ_PLANES_TWO 2'h1
`define PCQ_PLANES_FOUR 2'h2

// command word layout
`define PCQ_WORD_W 32
`define PCQ_OP_HI 31
`define PCQ_OP_LO 28
`define PCQ_ADDR_HI 23
`define PCQ_ADDR_LO 16
`define PCQ_MASK_HI 15
`define PCQ_MASK_LO 8
`define PCQ_VAL_HI 7
`define PCQ_VAL_LO 0
`define PCQ_LOCAL_IDX_HI 11
`define PCQ_LOCAL_IDX_LO 8

// operation codes
`define PCQ_OP_MOTION 4'h0
`define PCQ_OP_REPEAT 4'h1
`define PCQ_OP_CANCEL 4'h2
`define PCQ_OP_WAIT_LOCAL 4'h3
`define PCQ_OP_WAIT_PORT 4'h4

// input FIFO
`define PCQ_FIFO_DEPTH 16
`define PCQ_FIFO_W 34

// cycles after a port address change before the synchronised data is trusted
`define PCQ_PORT_SETTLE 2'h3

`endif

// File: pcq_pkg.sv
/*
  Types of the plane command queue.
  Assumes pcq_consts.svh is available on the include path.
*/
package pcq_pkg;

  typedef enum logic [2:0]
  {
    PCQ_PICK = 3'h0,
    PCQ_FETCH = 3'h1,
    PCQ_DECODE = 3'h2,
    PCQ_ISSUE = 3'h3,
    PCQ_WAIT = 3'h4
  } pcq_state_t;

endpackage : pcq_pkg

// File: pcq_plane_command_queue.sv
/*
  Plane command queue: input FIFO, shared 8000-word queue memory split
  into 1, 2 or 4 plane partitions, and a command executor that hands
  motion commands to the per-plane processor and runs repeat, cancel
  and wait commands itself.
  Assumes one clock, synchronous reset, a command source holding its
  word until taken, and a processor that pulses cmd_done_i per command.
*/
`timescale 1ns/100ps
`include "pcq_consts.svh"

module pcq_fifo #(
  parameter int WIDTH = `PCQ_FIFO_W,
  parameter int DEPTH = `PCQ_FIFO_DEPTH
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic flush_i,
  // fill side
  input wire logic in_valid_i,
  input wire logic [WIDTH-1:0] in_data_i,
  output logic in_ready_o,
  // drain side
  output logic out_valid_o,
  output logic [WIDTH-1:0] out_data_o,
  input wire logic out_ready_i
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wp_reg;
  logic [AW-1:0] rp_reg;
  logic [AW:0] cnt_reg;
  logic [AW:0] cnt_next;
  logic push;
  logic pop;

  assign push = in_valid_i && in_ready_o;
  assign pop = out_valid_o && out_ready_i;
  assign out_valid_o = (cnt_reg != '0);
  assign out_data_o = mem[rp_reg];

  always_comb
  begin
    cnt_next = cnt_reg;
    if (push && !pop)
      cnt_next = cnt_reg + (AW+1)'(1);
    else if (pop && !push)
      cnt_next = cnt_reg - (AW+1)'(1);
  end

  always_ff @(posedge clk_i)
  begin
    if (push)
      mem[wp_reg] <= in_data_i;
  end

  // ready is registered so the source sees it straight from a flop
  always_ff @(posedge clk_i)
  begin
    if (reset_i || flush_i)
    begin
      wp_reg <= '0;
      rp_reg <= '0;
      cnt_reg <= '0;
      in_ready_o <= 1'b1;
    end
    else
    begin
      if (push)
        wp_reg <= wp_reg + AW'(1);
      if (pop)
        rp_reg <= rp_reg + AW'(1);
      cnt_reg <= cnt_next;
      in_ready_o <= (cnt_next != (AW+1)'(DEPTH));
    end
  end
endmodule : pcq_fifo

// Functional notes
// - an 8000-word internal memory stores command sets awaiting processing
// - each command is held until processed, then its storage is released
// - with one plane selected, that plane may use all 8000 words
// - with two planes selected, each plane may use 4000 words
// - with four planes selected, each plane may use 2000 words
// - a full queue refuses new commands; the source holds until space appears
// - repeat-from-top moves the read point back to the first entry
// - cancel-repeat clears the pending repeat and decodes the following command
// - wait-for-input stalls the next command until the input condition holds
// - local wait picks one of sixteen inputs and a required level
// - port wait stalls until a whole expansion port equals a pattern
// - per-bit port wait compares chosen bits of one port address
// - several listed bits must all match at the same time
// - abort empties the queue and releases all space
// - plane count is one, two or four, setting the number of partitions
module pcq_plane_command_queue (
  // clock and reset
  input wire logic clk_i,
  input wire logic reset_i,
  // configuration and abort
  input wire logic [1:0] plane_count_i,
  input wire logic abort_i,
  // command source
  input wire logic src_valid_i,
  input wire logic [1:0] src_plane_i,
  input wire logic [`PCQ_WORD_W-1:0] src_data_i,
  output logic src_ready_o,
  // per-plane command processor
  output logic cmd_valid_o,
  output logic [1:0] cmd_plane_o,
  output logic [`PCQ_WORD_W-1:0] cmd_data_o,
  input wire logic cmd_done_i,
  // wait inputs
  input wire logic [15:0] local_in_i,
  input wire logic [7:0] exp_data_i,
  output logic [7:0] expansion_port_address_o,
  // status
  output logic [3:0] plane_full_o,
  output logic waiting_o
);
  localparam int NP = `PCQ_MAX_PLANES;
  localparam int AW = `PCQ_ADDR_W;

  logic [`PCQ_WORD_W-1:0] qmem [`PCQ_QUEUE_WORDS];
  logic [`PCQ_WORD_W-1:0] rd_q;
  logic [1:0] ncode_reg;
  logic [AW-1:0] psize;
  logic [AW-1:0] base [NP];
  logic [AW-1:0] wr_reg [NP];
  logic [AW-1:0] rd_reg [NP];
  logic [AW-1:0] head_reg [NP];
  logic [AW-1:0] cnt_reg [NP];
  logic [AW-1:0] ret_reg [NP];
  logic [NP-1:0] loop_reg;
  logic [NP-1:0] cancel_pend_reg;
  logic [NP-1:0] plane_en;
  logic [NP-1:0] full;
  logic [NP-1:0] pending;
  pcq_pkg::pcq_state_t state_reg;
  logic [1:0] sel_reg;
  logic [1:0] settle_reg;
  logic [15:0] loc_meta_reg;
  logic [15:0] loc_sync_reg;
  logic [7:0] exp_meta_reg;
  logic [7:0] exp_sync_reg;
  logic f_valid;
  logic [`PCQ_FIFO_W-1:0] f_data;
  logic f_ready;
  logic [1:0] w_plane;
  logic [`PCQ_WORD_W-1:0] w_word;
  logic [3:0] w_op;
  logic do_write;
  logic [3:0] d_op;
  logic do_complete;
  logic do_jump;
  logic do_cancel_free;
  logic cond_met;
  logic [1:0] pick;
  logic pick_ok;

  function automatic logic [AW-1:0] size_of(input logic [1:0] code);
    case (code)
      `PCQ_PLANES_TWO: size_of = `PCQ_SIZE_TWO_PLANES;
      `PCQ_PLANES_FOUR: size_of = `PCQ_SIZE_FOUR_PLANES;
      default: size_of = `PCQ_SIZE_ONE_PLANE;
    endcase
  endfunction : size_of

  function automatic logic [NP-1:0] enables_of(input logic [1:0] code);
    case (code)
      `PCQ_PLANES_TWO: enables_of = 4'h3;
      `PCQ_PLANES_FOUR: enables_of = 4'hF;
      default: enables_of = 4'h1;
    endcase
  endfunction : enables_of

  // codes other than one/two/four fall back to a single plane
  assign psize = size_of(ncode_reg);
  assign plane_en = enables_of(ncode_reg);

  always_comb
  begin
    for (int p = 0; p < NP; p++)
    begin
      base[p] = AW'(p * 32'(psize));
      full[p] = (cnt_reg[p] == psize);
      pending[p] = plane_en[p] && (cnt_reg[p] != ret_reg[p]);
    end
  end

  function automatic logic [AW-1:0] step(input logic [AW-1:0] ptr, input logic [AW-1:0] b,
                                         input logic [AW-1:0] sz);
    step = (ptr == b + sz - AW'(1)) ? b : ptr + AW'(1);
  endfunction : step

  // input FIFO
  pcq_fifo #(
    .WIDTH(`PCQ_FIFO_W),
    .DEPTH(`PCQ_FIFO_DEPTH)
  ) pcq_fifo_i (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .flush_i(abort_i),
    .in_valid_i(src_valid_i),
    .in_data_i({src_plane_i, src_data_i}),
    .in_ready_o(src_ready_o),
    .out_valid_o(f_valid),
    .out_data_o(f_data),
    .out_ready_i(f_ready)
  );

  assign w_plane = f_data[`PCQ_FIFO_W-1:`PCQ_WORD_W];
  assign w_word = f_data[`PCQ_WORD_W-1:0];
  assign w_op = w_word[`PCQ_OP_HI:`PCQ_OP_LO];
  // words for a disabled plane are dropped; a full partition holds the FIFO head
  assign f_ready = !abort_i && (!plane_en[w_plane] || !full[w_plane]);
  assign do_write = f_valid && f_ready && plane_en[w_plane];

  // queue memory: one write port for the source, one read port for the executor
  always_ff @(posedge clk_i)
  begin
    if (do_write)
      qmem[wr_reg[w_plane]] <= w_word;
    rd_q <= qmem[rd_reg[sel_reg]];
  end

  // plane-count setting is taken at reset and at abort only
  always_ff @(posedge clk_i)
  begin
    if (reset_i || abort_i)
      ncode_reg <= plane_count_i;
  end

  // wait inputs come from outside the clock domain
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      loc_meta_reg <= 16'h0000;
      loc_sync_reg <= 16'h0000;
      exp_meta_reg <= 8'h00;
      exp_sync_reg <= 8'h00;
    end
    else
    begin
      loc_meta_reg <= local_in_i;
      loc_sync_reg <= loc_meta_reg;
      exp_meta_reg <= exp_data_i;
      exp_sync_reg <= exp_meta_reg;
    end
  end

  // executor decisions
  assign d_op = rd_q[`PCQ_OP_HI:`PCQ_OP_LO];
  assign do_jump = (state_reg == pcq_pkg::PCQ_DECODE) && (d_op == `PCQ_OP_REPEAT)
                   && !cancel_pend_reg[sel_reg];
  assign do_cancel_free = (state_reg == pcq_pkg::PCQ_DECODE) && (d_op == `PCQ_OP_REPEAT)
                          && cancel_pend_reg[sel_reg];

  always_comb
  begin
    if (rd_q[`PCQ_OP_HI:`PCQ_OP_LO] == `PCQ_OP_WAIT_LOCAL)
      cond_met = (loc_sync_reg[rd_q[`PCQ_LOCAL_IDX_HI:`PCQ_LOCAL_IDX_LO]] == rd_q[`PCQ_VAL_LO]);
    else
      cond_met = (((exp_sync_reg ^ rd_q[`PCQ_VAL_HI:`PCQ_VAL_LO]) & rd_q[`PCQ_MASK_HI:`PCQ_MASK_LO])
                  == 8'h00) && (settle_reg == 2'h0);
  end

  always_comb
  begin
    do_complete = 1'b0;
    case (state_reg)
      pcq_pkg::PCQ_DECODE: do_complete = (d_op != `PCQ_OP_MOTION) && (d_op != `PCQ_OP_REPEAT)
                                         && (d_op != `PCQ_OP_WAIT_LOCAL) && (d_op != `PCQ_OP_WAIT_PORT);
      pcq_pkg::PCQ_ISSUE: do_complete = cmd_done_i;
      pcq_pkg::PCQ_WAIT: do_complete = cond_met;
      default: do_complete = 1'b0;
    endcase
  end

  // round-robin choice of the next plane with a pending command
  always_comb
  begin
    logic [1:0] cand;
    cand = 2'h0;
    pick = sel_reg;
    pick_ok = 1'b0;
    for (int k = 1; k <= NP; k++)
    begin
      cand = sel_reg + 2'(k);
      if (!pick_ok && pending[cand])
      begin
        pick = cand;
        pick_ok = 1'b1;
      end
    end
  end

  // per-plane pointers, occupancy and repeat bookkeeping
  always_ff @(posedge clk_i)
  begin
    if (reset_i || abort_i)
    begin
      for (int p = 0; p < NP; p++)
      begin
        wr_reg[p] <= AW'(p * 32'(size_of(plane_count_i)));
        rd_reg[p] <= AW'(p * 32'(size_of(plane_count_i)));
        head_reg[p] <= AW'(p * 32'(size_of(plane_count_i)));
        cnt_reg[p] <= '0;
        ret_reg[p] <= '0;
      end
      loop_reg <= 4'h0;
      cancel_pend_reg <= 4'h0;
    end
    else
    begin
      for (int p = 0; p < NP; p++)
      begin
        logic wr_hit;
        logic ex_hit;
        logic [AW-1:0] dec;
        wr_hit = do_write && (w_plane == 2'(p));
        ex_hit = (sel_reg == 2'(p));
        dec = '0;
        if (wr_hit)
          wr_reg[p] <= step(wr_reg[p], base[p], psize);
        if (ex_hit && do_complete)
        begin
          rd_reg[p] <= step(rd_reg[p], base[p], psize);
          if (loop_reg[p])
            ret_reg[p] <= ret_reg[p] + AW'(1);
          else
          begin
            head_reg[p] <= step(head_reg[p], base[p], psize);
            dec = AW'(1);
          end
        end
        if (ex_hit && do_jump)
        begin
          rd_reg[p] <= head_reg[p];
          ret_reg[p] <= '0;
        end
        if (ex_hit && do_cancel_free)
        begin
          rd_reg[p] <= step(rd_reg[p], base[p], psize);
          head_reg[p] <= step(rd_reg[p], base[p], psize);
          ret_reg[p] <= '0;
          dec = ret_reg[p] + AW'(1);
        end
        cnt_reg[p] <= cnt_reg[p] + AW'(wr_hit) - dec;
        // set wins over clear when both land in one cycle
        if (ex_hit && do_cancel_free)
        begin
          loop_reg[p] <= 1'b0;
          cancel_pend_reg[p] <= 1'b0;
        end
        if (wr_hit && (w_op == `PCQ_OP_REPEAT))
          loop_reg[p] <= 1'b1;
        if (wr_hit && (w_op == `PCQ_OP_CANCEL) && loop_reg[p])
          cancel_pend_reg[p] <= 1'b1;
      end
    end
  end

  // executor state machine
  always_ff @(posedge clk_i)
  begin
    if (reset_i || abort_i)
    begin
      state_reg <= pcq_pkg::PCQ_PICK;
      sel_reg <= 2'h0;
      settle_reg <= 2'h0;
    end
    else
    begin
      case (state_reg)
        pcq_pkg::PCQ_PICK:
        begin
          if (pick_ok)
          begin
            sel_reg <= pick;
            state_reg <= pcq_pkg::PCQ_FETCH;
          end
        end
        pcq_pkg::PCQ_FETCH:
          state_reg <= pcq_pkg::PCQ_DECODE;
        pcq_pkg::PCQ_DECODE:
        begin
          settle_reg <= `PCQ_PORT_SETTLE;
          if (d_op == `PCQ_OP_MOTION)
            state_reg <= pcq_pkg::PCQ_ISSUE;
          else if ((d_op == `PCQ_OP_WAIT_LOCAL) || (d_op == `PCQ_OP_WAIT_PORT))
            state_reg <= pcq_pkg::PCQ_WAIT;
          else
            state_reg <= pcq_pkg::PCQ_PICK;
        end
        pcq_pkg::PCQ_ISSUE:
        begin
          if (cmd_done_i)
            state_reg <= pcq_pkg::PCQ_PICK;
        end
        pcq_pkg::PCQ_WAIT:
        begin
          if (settle_reg != 2'h0)
            settle_reg <= settle_reg - 2'h1;
          if (cond_met)
            state_reg <= pcq_pkg::PCQ_PICK;
        end
        default:
          state_reg <= pcq_pkg::PCQ_PICK;
      endcase
    end
  end

  // processor handshake: valid stands until the processor reports completion
  always_ff @(posedge clk_i)
  begin
    if (reset_i || abort_i)
    begin
      cmd_valid_o <= 1'b0;
      cmd_plane_o <= 2'h0;
      cmd_data_o <= '0;
    end
    else if ((state_reg == pcq_pkg::PCQ_DECODE) && (d_op == `PCQ_OP_MOTION))
    begin
      cmd_valid_o <= 1'b1;
      cmd_plane_o <= sel_reg;
      cmd_data_o <= rd_q;
    end
    else if ((state_reg == pcq_pkg::PCQ_ISSUE) && cmd_done_i)
      cmd_valid_o <= 1'b0;
  end

  // expansion port address and status outputs
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      expansion_port_address_o <= 8'h00;
      plane_full_o <= 4'h0;
      waiting_o <= 1'b0;
    end
    else
    begin
      if ((state_reg == pcq_pkg::PCQ_DECODE) && (d_op == `PCQ_OP_WAIT_PORT))
        expansion_port_address_o <= rd_q[`PCQ_ADDR_HI:`PCQ_ADDR_LO];
      plane_full_o <= full & plane_en;
      waiting_o <= (state_reg == pcq_pkg::PCQ_WAIT) && !cond_met;
    end
  end
endmodule : pcq_plane_command_queue

// File: pcq_proc_model.sv
/*
  Behavioural per-plane command processor: completes each offered command
  after three cycles unless stalled, and logs what it completed.
  Assumes the queue holds cmd_valid until the done pulse.
*/
`timescale 1ns/100ps
`include "pcq_consts.svh"

module pcq_proc_model (
  // clock and reset
  input wire logic clk_i,
  input wire logic reset_i,
  // command port
  input wire logic cmd_valid_i,
  input wire logic [1:0] cmd_plane_i,
  input wire logic [`PCQ_WORD_W-1:0] cmd_data_i,
  output logic done_o,
  // bench control
  input wire logic stall_i
);
  logic [1:0] cnt_reg;
  logic [`PCQ_WORD_W-1:0] log_data [0:63];
  logic [1:0] log_plane [0:63];
  int log_cnt;

  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      done_o <= 1'b0;
      cnt_reg <= 2'h0;
      log_cnt <= 0;
    end
    else
    begin
      done_o <= 1'b0;
      // a dropped command restarts the count so a stale done never lands
      if (!cmd_valid_i || done_o)
        cnt_reg <= 2'h0;
      else if (!stall_i)
      begin
        cnt_reg <= cnt_reg + 2'h1;
        if (cnt_reg == 2'h2)
        begin
          done_o <= 1'b1;
          log_data[log_cnt[5:0]] <= cmd_data_i;
          log_plane[log_cnt[5:0]] <= cmd_plane_i;
          log_cnt <= log_cnt + 1;
        end
      end
    end
  end
endmodule : pcq_proc_model

// File: pcq_props.sv
/*
  Port checker of the plane command queue, bound to its top module.
  Assumes one clock and a synchronous active-high reset.
*/
`timescale 1ns/100ps
`include "pcq_consts.svh"

module pcq_props (
  // clock and reset
  input wire logic clk_i,
  input wire logic reset_i,
  // watched ports
  input wire logic [1:0] plane_count_i,
  input wire logic abort_i,
  input wire logic src_ready_o,
  input wire logic cmd_valid_o,
  input wire logic [1:0] cmd_plane_o,
  input wire logic [`PCQ_WORD_W-1:0] cmd_data_o,
  input wire logic cmd_done_i,
  input wire logic [15:0] local_in_i,
  input wire logic [7:0] exp_data_i,
  input wire logic [7:0] expansion_port_address_o,
  input wire logic [3:0] plane_full_o,
  input wire logic waiting_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (reset_i);

  a_reset_empty: assert property ($fell(reset_i) |-> src_ready_o && !cmd_valid_o && !waiting_o)
    else $error("queue not empty after reset");
  a_cmd_holds: assert property (cmd_valid_o && !cmd_done_i && !abort_i |=>
    cmd_valid_o && $stable(cmd_data_o) && $stable(cmd_plane_o))
    else $error("command dropped before done");
  a_done_release: assert property (cmd_valid_o && cmd_done_i |=> !cmd_valid_o [*3])
    else $error("command not released after done");
  a_abort_empty: assert property (abort_i |=> !cmd_valid_o && src_ready_o)
    else $error("abort left queue busy");
  a_one_plane: assert property (plane_count_i == `PCQ_PLANES_ONE |-> plane_full_o[3:1] == 3'h0)
    else $error("disabled plane reports full");
  a_two_planes: assert property (plane_count_i == `PCQ_PLANES_TWO |-> plane_full_o[3:2] == 2'h0)
    else $error("disabled plane reports full");
  a_wait_stalls: assert property (waiting_o |-> !cmd_valid_o)
    else $error("command issued during wait");
  a_port_hold: assert property (waiting_o && $past(waiting_o) && !$past(abort_i) |->
    $stable(expansion_port_address_o))
    else $error("port address moved during wait");
  a_sync_delay: assert property ((waiting_o && !abort_i && $stable(local_in_i) && $stable(exp_data_i)) [*6]
    |=> waiting_o)
    else $error("wait released without input change");

  cover property (cmd_valid_o && cmd_done_i);
  cover property ($fell(waiting_o));
  cover property (plane_full_o != 4'h0 && !src_ready_o);
endmodule : pcq_props

bind pcq_plane_command_queue pcq_props pcq_props_i (.clk_i, .reset_i, .plane_count_i, .abort_i, .src_ready_o,
  .cmd_valid_o, .cmd_plane_o, .cmd_data_o, .cmd_done_i, .local_in_i, .exp_data_i, .expansion_port_address_o,
  .plane_full_o, .waiting_o);

// File: tb_plane_command_queue.sv
/*
  Self-checking bench of the plane command queue with a processor model.
  Assumes the design, constants header and processor model are compiled first.
*/
`timescale 1ns/100ps
`include "pcq_consts.svh"

module tb_plane_command_queue;
  logic clk_i, reset_i, abort_i, src_valid_i, src_ready_o, cmd_valid_o, cmd_done_i, waiting_o, stall;
  logic [1:0] plane_count_i, src_plane_i, cmd_plane_o;
  logic [31:0] src_data_i, cmd_data_o;
  logic [15:0] local_in_i;
  logic [7:0] exp_data_i, expansion_port_address_o;
  logic [3:0] plane_full_o;
  int num_errors;
  int cmp_count;

  pcq_plane_command_queue pcq_plane_command_queue_i (.clk_i, .reset_i, .plane_count_i, .abort_i, .src_valid_i,
    .src_plane_i, .src_data_i, .src_ready_o, .cmd_valid_o, .cmd_plane_o, .cmd_data_o, .cmd_done_i, .local_in_i,
    .exp_data_i, .expansion_port_address_o, .plane_full_o, .waiting_o);
  pcq_proc_model pcq_proc_model_i (.clk_i, .reset_i, .cmd_valid_i(cmd_valid_o), .cmd_plane_i(cmd_plane_o),
    .cmd_data_i(cmd_data_o), .done_o(cmd_done_i), .stall_i(stall));

  initial
  begin
    clk_i = 1'b0;
    forever #2 clk_i = ~clk_i;
  end

  task check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task give_verdict;
    $display("compares %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : give_verdict

  task bail;
    check(32'h0, 32'h1);
    give_verdict();
  endtask : bail

  function logic [31:0] mot(input int x);
    return {`PCQ_OP_MOTION, x[27:0]};
  endfunction : mot

  function logic [31:0] last_log;
    return pcq_proc_model_i.log_data[(pcq_proc_model_i.log_cnt - 1) & 63];
  endfunction : last_log

  task do_reset(input logic [1:0] pc);
    @(posedge clk_i);
    plane_count_i <= pc;
    reset_i <= 1'b1;
    repeat (4) @(posedge clk_i);
    reset_i <= 1'b0;
    @(posedge clk_i);
  endtask : do_reset

  // the word stays offered until an edge sees ready high
  task push(input logic [1:0] p, input logic [31:0] d);
    int k;
    @(posedge clk_i);
    src_valid_i <= 1'b1;
    src_plane_i <= p;
    src_data_i <= d;
    for (k = 0; k < 300; k++)
    begin
      @(posedge clk_i);
      if (src_ready_o === 1'b1)
        break;
    end
    src_valid_i <= 1'b0;
    if (k == 300)
      bail();
  endtask : push

  task wait_log(input int n);
    int k;
    for (k = 0; k < 3000 && pcq_proc_model_i.log_cnt < n; k++)
      @(posedge clk_i);
    if (k == 3000)
      bail();
  endtask : wait_log

  task test_order;
    do_reset(`PCQ_PLANES_TWO);
    push(2'h1, mot(1));
    push(2'h3, mot(9));
    push(2'h1, mot(2));
    wait_log(2);
    repeat (30) @(posedge clk_i);
    check(pcq_proc_model_i.log_cnt, 2);
    check(pcq_proc_model_i.log_data[0], mot(1));
    check(pcq_proc_model_i.log_data[1], mot(2));
    check(pcq_proc_model_i.log_plane[1], 2'h1);
    $display("test_order done");
  endtask : test_order

  task test_fill;
    logic [1:0] pcs [3];
    int szs [3];
    int pls [3];
    int i, acc, idle, n;
    pcs = '{`PCQ_PLANES_ONE, `PCQ_PLANES_TWO, `PCQ_PLANES_FOUR};
    szs = '{`PCQ_SIZE_ONE_PLANE, `PCQ_SIZE_TWO_PLANES, `PCQ_SIZE_FOUR_PLANES};
    pls = '{0, 1, 3};
    for (i = 0; i < 3; i++)
    begin
      stall <= 1'b1;
      do_reset(pcs[i]);
      src_valid_i <= 1'b1;
      src_plane_i <= 2'(pls[i]);
      src_data_i <= mot(0);
      acc = 0;
      idle = 0;
      while (idle < 40 && acc < 9000)
      begin
        @(posedge clk_i);
        if (src_ready_o === 1'b1)
        begin
          acc++;
          idle = 0;
          src_data_i <= mot(acc);
        end
        else
          idle++;
      end
      n = szs[i] + `PCQ_FIFO_DEPTH;
      check(acc >= n && acc <= n + 2, 1);
      check(plane_full_o, 4'h1 << pls[i]);
      check(src_ready_o, 0);
      stall <= 1'b0;
      for (n = 0; n < 300 && src_ready_o !== 1'b1; n++)
        @(posedge clk_i);
      check(n < 300, 1);
      if (n == 300)
        bail();
      src_valid_i <= 1'b0;
      abort_i <= 1'b1;
      @(posedge clk_i);
      abort_i <= 1'b0;
      repeat (3) @(posedge clk_i);
      #1;
      n = pcq_proc_model_i.log_cnt;
      check(plane_full_o, 4'h0);
      repeat (20) @(posedge clk_i);
      check(pcq_proc_model_i.log_cnt, n);
    end
    $display("test_fill done");
  endtask : test_fill

  task test_repeat;
    int k;
    do_reset(`PCQ_PLANES_ONE);
    push(2'h0, mot(1));
    push(2'h0, mot(2));
    push(2'h0, {`PCQ_OP_REPEAT, 28'h0});
    wait_log(5);
    check(pcq_proc_model_i.log_data[2], mot(1));
    check(pcq_proc_model_i.log_data[3], mot(2));
    push(2'h0, {`PCQ_OP_CANCEL, 28'h0});
    push(2'h0, mot(3));
    for (k = 0; k < 3000 && last_log() !== mot(3); k++)
      @(posedge clk_i);
    check(last_log(), mot(3));
    if (k == 3000)
      bail();
    k = pcq_proc_model_i.log_cnt;
    repeat (40) @(posedge clk_i);
    check(pcq_proc_model_i.log_cnt, k);
    $display("test_repeat done");
  endtask : test_repeat

  // at least one watched input bit differs between the refused and the accepted values
  task run_wait(input logic [31:0] w, input bit port, input logic [15:0] bad, input logic [15:0] good);
    int n;
    @(posedge clk_i);
    if (port)
      exp_data_i <= bad[7:0];
    else
      local_in_i <= bad;
    n = pcq_proc_model_i.log_cnt;
    push(2'h0, w);
    push(2'h0, mot(5));
    repeat (12) @(posedge clk_i);
    #1;
    check(waiting_o, 1);
    check(pcq_proc_model_i.log_cnt, n);
    if (port)
      check(expansion_port_address_o, w[23:16]);
    @(posedge clk_i);
    if (port)
      exp_data_i <= good[7:0];
    else
      local_in_i <= good;
    wait_log(n + 1);
    check(last_log(), mot(5));
  endtask : run_wait

  task test_wait;
    do_reset(`PCQ_PLANES_ONE);
    run_wait({`PCQ_OP_WAIT_LOCAL, 16'h0, 4'hF, 8'h01}, 0, 16'h7FFF, 16'h8000);
    run_wait({`PCQ_OP_WAIT_LOCAL, 16'h0, 4'h3, 8'h00}, 0, 16'h0008, 16'hFFF7);
    run_wait({`PCQ_OP_WAIT_PORT, 4'h0, 8'h5A, 8'hFF, 8'hA5}, 1, 16'h00A4, 16'h00A5);
    run_wait({`PCQ_OP_WAIT_PORT, 4'h0, 8'h3C, 8'h03, 8'h03}, 1, 16'h0001, 16'h00F3);
    $display("test_wait done");
  endtask : test_wait

  initial
  begin
    num_errors = 0;
    cmp_count = 0;
    reset_i = 1'b1;
    plane_count_i = 2'h0;
    abort_i = 1'b0;
    src_valid_i = 1'b0;
    src_plane_i = 2'h0;
    src_data_i = 32'h0;
    local_in_i = 16'h0;
    exp_data_i = 8'h0;
    stall = 1'b0;
    test_order();
    test_repeat();
    test_wait();
    test_fill();
    give_verdict();
  end
endmodule : tb_plane_command_queue
